// File: gdi_core.sv
// Purpose: Device side of the instrument bus: commands, addressing, handshakes
// Assumes: Bus lines asserted-high; pins pass a three-stage filter
// Notes: Received data waits in a two-entry buffer; a full buffer holds NRFD
// Operation
// - Under ATN decode 01 GTL, 04 SDC, 08 GET, 11 LLO, 14 DCL, 18 SPE, 19 SPD.
// - Under ATN 20-3F listen, 40-5F talk, 60-7F secondary; 3F unlisten, 5F untalk.
// - Own listen address is the primary address ORed with 20.
// - Own talk address is the primary address ORed with 40.
// - Addressed commands act only while the device is addressed to listen.
// - After addressing, bytes sent with ATN false are device data.
// - Data goes onto the bus only once addressed to talk or talk-only.
// - Any listen-group byte removes the talker state.
// - Data accepted only when listening; any talk-group byte removes listening.
// - No parallel poll reply; ATN, IFC and REN are never driven.
// - Secondary group bytes are ignored; no extended addressing.
// - Service requests assert SRQ; serial poll returns the status byte.
// - Remote under REN on listen addressing, lockout on LLO, local on GTL.
// - Clear on DCL, and on SDC while addressed to listen.
// - GET starts a reading.
// - Talker sources bytes with DAV against NRFD and NDAC.
// - Acceptor holds NRFD and NDAC so each byte is taken before removal.
module gdi_core
  import gdi_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic [4:0] my_addr_in,
  input wire logic talk_only_in,
  input gdi_pins_t bus_in,
  output gdi_pins_t bus_out,
  output gdi_pins_t bus_oe_out,
  output gdi_rx_t rx_word_out,
  output logic rx_valid_out,
  input wire logic rx_ready_in,
  input wire logic [7:0] tx_data_in,
  input wire logic tx_eoi_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out,
  input wire logic [7:0] stb_in,
  input wire logic srq_req_in,
  output logic listen_out,
  output logic talk_out,
  output logic spoll_out,
  output logic remote_out,
  output logic lockout_out,
  output logic dev_clear_out,
  output logic trigger_out
);
  gdi_pins_t s1_r, s2_r, s3_r, bus_f;
  gdi_acc_t acc_r, acc_nxt;
  gdi_src_t src_r, src_nxt;
  logic [6:0] cmd_r;
  logic cmd_stb_r;
  logic buf_ready;
  logic push;
  gdi_rx_t push_word;
  logic acc_on;
  logic talk_act;
  logic [7:0] src_data_r;
  logic src_eoi_r;
  logic src_is_stb_r;
  logic stb_sent_r;
  logic svc_r;
  logic srq_req_q;
  logic [6:0] settle_r;
  logic load_tx;
  logic load_stb;
  logic done_byte;
  logic [6:0] mla;
  logic [6:0] mta;
  logic nrfd_o_r, ndac_o_r, nrfd_oe_r, ndac_oe_r;
  logic [7:0] dio_o_r;
  logic [7:0] dio_oe_r;
  logic eoi_o_r, dav_o_r, eoi_oe_r, dav_oe_r;
  logic srq_o_r, srq_oe_r;
  logic [2:0] ctl_o_r;
  logic [2:0] ctl_oe_r;

  assign mla = LAG_BASE | {2'b00, my_addr_in};
  assign mta = TAG_BASE | {2'b00, my_addr_in};

  // Each concern owns its line flops; the bus structs only gather them, so every flop has one writer
  assign bus_out = {ctl_o_r, srq_o_r, eoi_o_r, dav_o_r, nrfd_o_r, ndac_o_r, dio_o_r};
  assign bus_oe_out = {ctl_oe_r, srq_oe_r, eoi_oe_r, dav_oe_r, nrfd_oe_r, ndac_oe_r, dio_oe_r};

  // Three-stage pin filter; the first stage feeds only the second
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      s1_r <= PINS_RST;
      s2_r <= PINS_RST;
      s3_r <= PINS_RST;
      bus_f <= PINS_RST;
    end
    else
    begin
      s1_r <= bus_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      bus_f <= (s2_r & s3_r) | (bus_f & (s2_r ^ s3_r));
    end
  end

  // Acceptor is active for every command byte, and for data only when listening
  assign acc_on = bus_f.atn || listen_out;
  assign push = acc_r == ACC_RDY && bus_f.dav && !bus_f.atn;
  assign push_word = '{eoi: bus_f.eoi, data: bus_f.dio};

  // Acceptor sequence
  always_comb
  begin
    acc_nxt = acc_r;
    unique case (acc_r)
      ACC_IDLE:
        if (acc_on && !bus_f.dav && (bus_f.atn || buf_ready))
          acc_nxt = ACC_RDY;
      ACC_RDY:
        // ATN may fall while ready with a full buffer; back off so the byte is not lost
        if (!acc_on || (!bus_f.atn && !buf_ready))
          acc_nxt = ACC_IDLE;
        else if (bus_f.dav)
          acc_nxt = ACC_TAKE;
      ACC_TAKE:
        if (!bus_f.dav)
          acc_nxt = ACC_IDLE;
    endcase
  end

  // Acceptor state and its line drive, both from the next state
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      acc_r <= ACC_IDLE;
      nrfd_o_r <= 1'b0;
      ndac_o_r <= 1'b0;
      nrfd_oe_r <= 1'b0;
      ndac_oe_r <= 1'b0;
    end
    else
    begin
      acc_r <= acc_nxt;
      // Idle but active holds both lines so no byte slips past
      nrfd_o_r <= acc_nxt != ACC_RDY;
      ndac_o_r <= acc_nxt != ACC_TAKE;
      nrfd_oe_r <= acc_on && acc_nxt != ACC_RDY;
      ndac_oe_r <= acc_on && acc_nxt != ACC_TAKE;
    end
  end

  // Latch command bytes; bit 7 is not part of the code
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      cmd_r <= '0;
      cmd_stb_r <= 1'b0;
    end
    else
    begin
      cmd_stb_r <= acc_r == ACC_RDY && bus_f.dav && bus_f.atn;
      if (acc_r == ACC_RDY && bus_f.dav)
        cmd_r <= bus_f.dio[6:0];
    end
  end

  // Addressing; own address wins over the group that would clear it
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      listen_out <= 1'b0;
      talk_out <= 1'b0;
    end
    else if (bus_f.ifc)
    begin
      listen_out <= 1'b0;
      talk_out <= 1'b0;
    end
    else if (cmd_stb_r)
    begin
      if (cmd_r[6:5] == GRP_LAG)
      begin
        talk_out <= 1'b0;
        if (cmd_r == mla)
          listen_out <= 1'b1;
        else if (cmd_r == CMD_UNL)
          listen_out <= 1'b0;
      end
      else if (cmd_r[6:5] == GRP_TAG)
      begin
        listen_out <= 1'b0;
        talk_out <= cmd_r == mta;
      end
      // Secondary group falls through untouched
    end
  end

  // Universal and addressed commands
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      dev_clear_out <= 1'b0;
      trigger_out <= 1'b0;
      spoll_out <= 1'b0;
    end
    else
    begin
      dev_clear_out <= cmd_stb_r && (cmd_r == CMD_DCL || (cmd_r == CMD_SDC && listen_out));
      trigger_out <= cmd_stb_r && cmd_r == CMD_GET && listen_out;
      if (bus_f.ifc || (cmd_stb_r && cmd_r == CMD_SPD))
        spoll_out <= 1'b0;
      else if (cmd_stb_r && cmd_r == CMD_SPE)
        spoll_out <= 1'b1;
    end
  end

  // Remote and lockout follow REN; local on an addressed GTL
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      remote_out <= 1'b0;
      lockout_out <= 1'b0;
    end
    else if (!bus_f.ren)
    begin
      remote_out <= 1'b0;
      lockout_out <= 1'b0;
    end
    else if (cmd_stb_r)
    begin
      if (cmd_r == mla)
        remote_out <= 1'b1;
      else if (cmd_r == CMD_GTL && listen_out)
        remote_out <= 1'b0;
      if (cmd_r == CMD_LLO)
        lockout_out <= 1'b1;
    end
  end

  // Received data path; a clear discards queued bytes
  gdi_buf2 #(
    .W($bits(gdi_rx_t))
  ) u_rx_buf (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .flush_in(dev_clear_out),
    .in_valid_in(push),
    .in_data_in(push_word),
    .in_ready_out(buf_ready),
    .out_valid_out(rx_valid_out),
    .out_data_out(rx_word_out),
    .out_ready_in(rx_ready_in)
  );

  // Talker is never active under ATN, so a parallel poll sees nothing from us
  assign talk_act = (talk_out || talk_only_in) && !bus_f.atn;
  assign load_stb = src_r == SRC_IDLE && talk_act && spoll_out && !stb_sent_r;
  assign load_tx = tx_ready_out && tx_valid_in;
  assign done_byte = src_r == SRC_DAV && !bus_f.ndac;

  // Source sequence
  always_comb
  begin
    src_nxt = src_r;
    unique case (src_r)
      SRC_IDLE:
        if (load_tx || load_stb)
          src_nxt = SRC_SET;
      SRC_SET:
        if (talk_act && settle_r == '0 && !bus_f.nrfd && bus_f.ndac)
          src_nxt = SRC_DAV;
      SRC_DAV:
        if (!talk_act)
          src_nxt = SRC_SET;
        else if (!bus_f.ndac)
          src_nxt = SRC_IDLE;
    endcase
  end

  // Source state, held byte and settle count
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      src_r <= SRC_IDLE;
      src_data_r <= '0;
      src_eoi_r <= 1'b0;
      src_is_stb_r <= 1'b0;
      settle_r <= '0;
    end
    else
    begin
      src_r <= src_nxt;
      if (load_stb)
      begin
        src_data_r <= {stb_in[7], svc_r, stb_in[5:0]};
        src_eoi_r <= 1'b0;
        src_is_stb_r <= 1'b1;
      end
      else if (load_tx)
      begin
        src_data_r <= tx_data_in;
        src_eoi_r <= tx_eoi_in;
        src_is_stb_r <= 1'b0;
      end
      // Restart settling whenever data is (re)placed on the lines
      if (src_nxt == SRC_SET && (src_r != SRC_SET || !talk_act))
        settle_r <= SETTLE_LOAD;
      else if (settle_r != '0)
        settle_r <= settle_r - 7'h01;
    end
  end

  // Source line drive; ready only when idle, talking and not polled
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      tx_ready_out <= 1'b0;
      dio_o_r <= '0;
      eoi_o_r <= 1'b0;
      dav_o_r <= 1'b0;
      dio_oe_r <= '0;
      eoi_oe_r <= 1'b0;
      dav_oe_r <= 1'b0;
    end
    else
    begin
      tx_ready_out <= src_nxt == SRC_IDLE && !load_tx && talk_act && !spoll_out;
      dio_o_r <= src_data_r;
      eoi_o_r <= src_eoi_r;
      dav_o_r <= src_nxt == SRC_DAV;
      dio_oe_r <= {8{src_r != SRC_IDLE && talk_act}};
      eoi_oe_r <= src_r != SRC_IDLE && talk_act && src_eoi_r;
      dav_oe_r <= talk_act;
    end
  end

  // Service request: a new request sets, a delivered status byte clears; set wins
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      svc_r <= 1'b0;
      srq_req_q <= 1'b0;
      stb_sent_r <= 1'b0;
    end
    else
    begin
      srq_req_q <= srq_req_in;
      if (srq_req_in && !srq_req_q)
        svc_r <= 1'b1;
      else if (done_byte && src_is_stb_r)
        svc_r <= 1'b0;
      if (!spoll_out)
        stb_sent_r <= 1'b0;
      else if (done_byte && src_is_stb_r)
        stb_sent_r <= 1'b1;
    end
  end

  // SRQ is open drain; controller-only lines are never enabled
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      srq_o_r <= 1'b0;
      srq_oe_r <= 1'b0;
      ctl_o_r <= 3'h0;
      ctl_oe_r <= 3'h0;
    end
    else
    begin
      srq_o_r <= svc_r;
      srq_oe_r <= svc_r;
      ctl_o_r <= 3'h0;
      ctl_oe_r <= 3'h0;
    end
  end

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!nrst_in);

  chk_ctrl_lines_off:
    assert property (!bus_oe_out.atn && !bus_oe_out.ifc && !bus_oe_out.ren)
    else $error("controller-only line enabled");

  chk_dio_only_talker:
    assert property (bus_oe_out.dio[0] |-> $past(talk_out || talk_only_in) && $past(!bus_f.atn))
    else $error("data driven while not talker");

  chk_take_releases_ndac:
    assert property (acc_r == ACC_RDY && bus_f.dav && acc_on && (bus_f.atn || buf_ready) |=> bus_out.nrfd && !bus_out.ndac)
    else $error("NDAC not released after latch");

  chk_full_holds_nrfd:
    assert property (acc_r == ACC_RDY && !bus_f.atn && !buf_ready |=> bus_out.nrfd && bus_out.ndac)
    else $error("data byte taken with receive buffer full");

  chk_ndac_back_on:
    assert property (acc_r == ACC_TAKE && !bus_f.dav |=> bus_out.ndac && acc_r == ACC_IDLE)
    else $error("NDAC not reasserted after DAV off");

  chk_mla_listen:
    assert property (cmd_stb_r && cmd_r == mla && !bus_f.ifc |=> listen_out && !talk_out)
    else $error("own listen address ignored");

  chk_mta_talk:
    assert property (cmd_stb_r && cmd_r == mta && !bus_f.ifc |=> talk_out && !listen_out)
    else $error("own talk address ignored");

  chk_scg_ignored:
    assert property (cmd_stb_r && cmd_r[6:5] == GRP_SCG && !bus_f.ifc |=> $stable(listen_out) && $stable(talk_out))
    else $error("secondary byte changed addressing");

  chk_sdc_addressed:
    assert property (cmd_stb_r && cmd_r == CMD_SDC ##1 !dev_clear_out |-> !$past(listen_out))
    else $error("SDC ignored while listening");

  chk_get_trigger:
    assert property (trigger_out |-> $past(cmd_stb_r) && $past(cmd_r) == CMD_GET)
    else $error("trigger without GET");

  chk_dav_needs_nrfd:
    assert property ($rose(bus_out.dav) |-> $past(!bus_f.nrfd && bus_f.ndac) && settle_r == '0)
    else $error("DAV raised before listeners ready");

  chk_llo_lockout:
    assert property (cmd_stb_r && cmd_r == CMD_LLO && bus_f.ren |=> lockout_out)
    else $error("LLO did not lock out");
endmodule : gdi_core

// File: gdi_pkg.sv
// Purpose: Shared types and constants for the instrument bus device port
// Assumes: Bus lines arrive as asserted-high levels; electrical drivers sit outside
// Notes: Command codes are compared on the low seven data bits only
package gdi_pkg;
  // One field per bus line, true meaning asserted
  typedef struct packed {
    logic atn;
    logic ifc;
    logic ren;
    logic srq;
    logic eoi;
    logic dav;
    logic nrfd;
    logic ndac;
    logic [7:0] dio;
  } gdi_pins_t;

  // A received data byte and its end mark
  typedef struct packed {
    logic eoi;
    logic [7:0] data;
  } gdi_rx_t;

  localparam gdi_pins_t PINS_RST = '0;

  // Command codes
  localparam logic [6:0] CMD_GTL = 7'h01;
  localparam logic [6:0] CMD_SDC = 7'h04;
  localparam logic [6:0] CMD_GET = 7'h08;
  localparam logic [6:0] CMD_LLO = 7'h11;
  localparam logic [6:0] CMD_DCL = 7'h14;
  localparam logic [6:0] CMD_SPE = 7'h18;
  localparam logic [6:0] CMD_SPD = 7'h19;
  localparam logic [6:0] CMD_UNL = 7'h3f;
  localparam logic [6:0] CMD_UNT = 7'h5f;
  localparam logic [6:0] LAG_BASE = 7'h20;
  localparam logic [6:0] TAG_BASE = 7'h40;
  // Group field in bits 6:5
  localparam logic [1:0] GRP_LAG = 2'h1;
  localparam logic [1:0] GRP_TAG = 2'h2;
  localparam logic [1:0] GRP_SCG = 2'h3;
  localparam int STB_RQS_BIT = 6;

  // Data settle time before DAV
  localparam int CLK_NS = 40;
  localparam int SETTLE_NS = 2000;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [6:0] SETTLE_LOAD = 7'(SETTLE_CYC);

  typedef enum logic [2:0] {
    ACC_IDLE = 3'b001,
    ACC_RDY = 3'b010,
    ACC_TAKE = 3'b100
  } gdi_acc_t;

  typedef enum logic [2:0] {
    SRC_IDLE = 3'b001,
    SRC_SET = 3'b010,
    SRC_DAV = 3'b100
  } gdi_src_t;
endpackage : gdi_pkg

// File: gdi_buf2.sv
// Purpose: Two-entry buffer with valid and ready on both sides
// Assumes: One clock; head entry always sits in slot 0
// Notes: All outputs come from flip-flops
module gdi_buf2
  import gdi_pkg::*;
#(
  parameter int W = 9
)
(
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic flush_in,
  input wire logic in_valid_in,
  input wire logic [W-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [W-1:0] out_data_out,
  input wire logic out_ready_in
);
  logic [W-1:0] slot1_r;
  logic v1_r;
  logic push;
  logic pop;

  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  // Shift register: pop moves slot 1 forward, so the head needs no mux at the port
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      out_valid_out <= 1'b0;
      v1_r <= 1'b0;
      out_data_out <= '0;
      slot1_r <= '0;
      in_ready_out <= 1'b1;
    end
    else if (flush_in)
    begin
      out_valid_out <= 1'b0;
      v1_r <= 1'b0;
      in_ready_out <= 1'b1;
    end
    else
    begin
      if (pop)
      begin
        out_valid_out <= v1_r || push;
        out_data_out <= v1_r ? slot1_r : in_data_in;
        v1_r <= v1_r && push;
        if (v1_r && push)
          slot1_r <= in_data_in;
        in_ready_out <= 1'b1;
      end
      else if (push)
      begin
        if (!out_valid_out)
        begin
          out_valid_out <= 1'b1;
          out_data_out <= in_data_in;
        end
        else
        begin
          v1_r <= 1'b1;
          slot1_r <= in_data_in;
          in_ready_out <= 1'b0;
        end
      end
    end
  end
endmodule : gdi_buf2

// File: gdi_ctl_model.sv
// Purpose: Bus controller model standing on the far side of the device port
// Assumes: Lines asserted-high; a released line reads not asserted (pull-ups)
// Notes: Source waits for a present acceptor before raising DAV
module gdi_ctl_model
  import gdi_pkg::*;
#(
  parameter int SETTLE = 4
)
(
  input wire logic core_clk_in,
  input gdi_pins_t bus_in,
  output gdi_pins_t ctl_out
);
  timeunit 1ns;
  timeprecision 1ns;

  // Nothing is driven until a task asks
  initial ctl_out = PINS_RST;

  // Uniline levels, changed only between handshakes
  task automatic lines(input logic atn, input logic ren, input logic ifc, input logic eoi);
    @(posedge core_clk_in);
    ctl_out.atn <= atn;
    ctl_out.ren <= ren;
    ctl_out.ifc <= ifc;
    ctl_out.eoi <= eoi;
  endtask : lines

  // Bounded wait on one wire condition
  task automatic await(input int sel, input int lim, output bit ok);
    ok = 1'h0;
    repeat (lim)
    begin
      @(posedge core_clk_in);
      case (sel)
        0: ok = bus_in.ndac && !bus_in.nrfd;
        1: ok = !bus_in.ndac;
        2: ok = bus_in.dav;
        default: ok = !bus_in.dav;
      endcase
      if (ok)
        break;
    end
  endtask : await

  // One byte as source; ATN stays as set until the next call changes it
  task automatic send(input logic atn, input logic [7:0] b, input logic eoi, input int lim, output bit ok);
    @(posedge core_clk_in);
    ctl_out.atn <= atn;
    ctl_out.nrfd <= 1'h0;
    ctl_out.ndac <= 1'h0;
    await(0, lim, ok);
    if (ok)
    begin
      ctl_out.dio <= b;
      ctl_out.eoi <= eoi;
      repeat (SETTLE) @(posedge core_clk_in);
      ctl_out.dav <= 1'h1;
      await(1, 400, ok);
      ctl_out.dav <= 1'h0;
      @(posedge core_clk_in);
      ctl_out.dio <= 8'h00;
      ctl_out.eoi <= 1'h0;
    end
  endtask : send

  // One byte as acceptor; left holding not-ready afterwards
  task automatic recv(output logic [8:0] got, output bit ok);
    @(posedge core_clk_in);
    ctl_out.ndac <= 1'h1;
    ctl_out.nrfd <= 1'h0;
    await(2, 400, ok);
    got = {bus_in.eoi, bus_in.dio};
    ctl_out.nrfd <= 1'h1;
    ctl_out.ndac <= 1'h0;
    if (ok)
      await(3, 400, ok);
    ctl_out.ndac <= 1'h1;
  endtask : recv
endmodule : gdi_ctl_model

// File: gdi_core_tb.sv
// Purpose: Self-checking bench for the device port
// Assumes: Controller model on the far side; primary address 16 hex
// Notes: Settle time kept at its real length; the run stays short anyway
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module gdi_core_tb
  import gdi_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;

  logic core_clk = 1'h0;
  logic nrst = 1'h0;
  logic [4:0] addr = 5'h16;
  logic talk_only = 1'h0;
  logic rx_ready = 1'h0;
  logic [7:0] tx_data = 8'h00;
  logic tx_eoi = 1'h0;
  logic tx_valid = 1'h0;
  logic [7:0] stb = 8'h85;
  logic srq_req = 1'h0;
  gdi_pins_t ctl, dut_o, dut_oe, wire_b;
  gdi_rx_t rx_word;
  logic rx_valid, tx_ready, listen, talk, spoll, remote, lockout, dclr, trig;
  int num_errors = 0;
  int n_tests = 0;
  int n_clr = 0;
  int n_trg = 0;
  bit ok;
  logic [8:0] got;

  // Open-collector wire: any party asserting wins
  assign wire_b = ctl | (dut_o & dut_oe);

  // 25 MHz clock
  initial forever #20 core_clk = ~core_clk;

  // Count one-cycle event pulses so scenarios can compare totals
  always @(posedge core_clk)
  begin
    if (dclr === 1'h1) n_clr <= n_clr + 1;
    if (trig === 1'h1) n_trg <= n_trg + 1;
  end

  gdi_core u_dut (.core_clk_in(core_clk), .nrst_in(nrst), .my_addr_in(addr), .talk_only_in(talk_only),
    .bus_in(wire_b), .bus_out(dut_o), .bus_oe_out(dut_oe), .rx_word_out(rx_word), .rx_valid_out(rx_valid),
    .rx_ready_in(rx_ready), .tx_data_in(tx_data), .tx_eoi_in(tx_eoi), .tx_valid_in(tx_valid),
    .tx_ready_out(tx_ready), .stb_in(stb), .srq_req_in(srq_req), .listen_out(listen), .talk_out(talk),
    .spoll_out(spoll), .remote_out(remote), .lockout_out(lockout), .dev_clear_out(dclr), .trigger_out(trig));

  gdi_ctl_model #(.SETTLE(4)) u_ctl (.core_clk_in(core_clk), .bus_in(wire_b), .ctl_out(ctl));

  // Counts, verdict and end of run
  task automatic print_verdict;
    $display("errors %0d tests %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  // A stalled handshake ends the run, since nothing after it means much
  task automatic need(input bit k);
    `CHK("handshake", 1'h1, k)
    if (!k)
      print_verdict;
  endtask : need

  // Command byte under ATN, then room for its effect to land
  task automatic cmd(input logic [7:0] b);
    u_ctl.send(1'h1, b, 1'h0, 400, ok);
    need(ok);
    repeat (3) @(posedge core_clk);
  endtask : cmd

  // Take the head word once shown; the buffer updates a cycle late
  task automatic pop(input gdi_rx_t e);
    repeat (2) @(posedge core_clk);
    repeat (20)
    begin
      if (rx_valid === 1'h1)
        break;
      @(posedge core_clk);
    end
    `CHK("rx valid", 1'h1, rx_valid)
    `CHK("rx word", e, rx_word)
    rx_ready <= 1'h1;
    @(posedge core_clk);
    rx_ready <= 1'h0;
  endtask : pop

  task automatic s_reset;
    `CHK("ctl line oe", 3'h0, {dut_oe.atn, dut_oe.ifc, dut_oe.ren})
    `CHK("dio oe idle", 8'h00, dut_oe.dio)
    `CHK("tx ready idle", 1'h0, tx_ready)
  endtask : s_reset

  task automatic s_listen;
    u_ctl.lines(1'h1, 1'h1, 1'h0, 1'h0);
    cmd(8'h3f);
    cmd(8'h21);
    `CHK("other listen addr", 1'h0, listen)
    cmd({3'h1, addr});
    `CHK("listen", 1'h1, listen)
    `CHK("remote", 1'h1, remote)
    cmd(8'h65);
    `CHK("secondary ignored", 1'h1, listen)
  endtask : s_listen

  // Two words fill the buffer; the third waits until the reader drains it
  task automatic s_rx;
    u_ctl.send(1'h0, 8'h2a, 1'h0, 400, ok);
    need(ok);
    u_ctl.send(1'h0, 8'h52, 1'h1, 400, ok);
    need(ok);
    u_ctl.send(1'h0, 8'h53, 1'h0, 150, ok);
    `CHK("full refuses", 1'h0, ok)
    `CHK("nrfd held", 1'h1, wire_b.nrfd)
    // A command under ATN readies the acceptor; dropping ATN with a full buffer must not take the byte
    cmd(8'h65);
    u_ctl.send(1'h0, 8'h53, 1'h0, 150, ok);
    `CHK("atn drop while full", 1'h0, ok)
    pop(9'h02a);
    pop(9'h152);
    u_ctl.send(1'h0, 8'h53, 1'h0, 400, ok);
    need(ok);
    pop(9'h053);
  endtask : s_rx

  task automatic s_cmds;
    int c0;
    int t0;
    c0 = n_clr;
    t0 = n_trg;
    cmd(8'h04);
    cmd(8'h08);
    cmd(8'h11);
    `CHK("sdc clears", c0 + 1, n_clr)
    `CHK("get triggers", t0 + 1, n_trg)
    `CHK("lockout", 1'h1, lockout)
    cmd(8'h01);
    `CHK("gtl local", 1'h0, remote)
    cmd(8'h3f);
    `CHK("unlisten", 1'h0, listen)
    cmd(8'h84);
    `CHK("sdc unaddressed", c0 + 1, n_clr)
    cmd(8'h14);
    `CHK("dcl clears", c0 + 2, n_clr)
  endtask : s_cmds

  task automatic s_talk;
    cmd({3'h1, addr});
    cmd({3'h2, addr});
    `CHK("talk", 1'h1, talk)
    `CHK("tag unlistens", 1'h0, listen)
    u_ctl.lines(1'h0, 1'h1, 1'h0, 1'h0);
    @(posedge core_clk);
    tx_data <= 8'hc5;
    tx_eoi <= 1'h1;
    tx_valid <= 1'h1;
    repeat (60)
    begin
      @(posedge core_clk);
      if (tx_ready === 1'h1)
        break;
    end
    tx_valid <= 1'h0;
    need(tx_ready === 1'h1);
    u_ctl.recv(got, ok);
    need(ok);
    `CHK("talker byte", 9'h1c5, got)
    cmd(8'h21);
    `CHK("lag untalks", 1'h0, talk)
  endtask : s_talk

  // Status byte carries the request flag in bit 6; delivery drops SRQ
  task automatic s_poll;
    @(posedge core_clk);
    srq_req <= 1'h1;
    repeat (6) @(posedge core_clk);
    `CHK("srq", 1'h1, wire_b.srq)
    cmd(8'h18);
    cmd({3'h2, addr});
    `CHK("poll mode", 1'h1, spoll)
    u_ctl.lines(1'h0, 1'h1, 1'h0, 1'h0);
    u_ctl.recv(got, ok);
    need(ok);
    `CHK("status byte", 8'hc5, got[7:0])
    repeat (4) @(posedge core_clk);
    `CHK("srq cleared", 1'h0, wire_b.srq)
    cmd(8'h19);
    `CHK("poll off", 1'h0, spoll)
    cmd(8'h5f);
    `CHK("untalk", 1'h0, talk)
  endtask : s_poll

  // Parallel poll on an addressed talker draws no reply; IFC and REN false then drop state
  task automatic s_ppoll;
    cmd({3'h2, addr});
    `CHK("talk before poll", 1'h1, talk)
    u_ctl.lines(1'h1, 1'h1, 1'h0, 1'h1);
    repeat (10) @(posedge core_clk);
    `CHK("no poll reply", 8'h00, dut_oe.dio)
    u_ctl.lines(1'h1, 1'h1, 1'h1, 1'h0);
    repeat (8) @(posedge core_clk);
    `CHK("ifc untalks", 1'h0, talk)
    `CHK("lockout held", 1'h1, lockout)
    u_ctl.lines(1'h1, 1'h0, 1'h0, 1'h0);
    repeat (8) @(posedge core_clk);
    `CHK("ren off local", 2'h0, {remote, lockout})
  endtask : s_ppoll

  // Main sequence
  initial
  begin
    repeat (6) @(posedge core_clk);
    nrst <= 1'h1;
    repeat (2) @(posedge core_clk);
    s_reset;
    s_listen;
    s_rx;
    s_cmds;
    s_talk;
    s_poll;
    s_ppoll;
    print_verdict;
  end
endmodule : gdi_core_tb
